/* rtl/timer_defines.svh */
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// channel register block, index in address bits 4:2
`define REG_CTRL 3'h0
`define REG_IER 3'h1
`define REG_STATUS 3'h2
`define REG_CNT 3'h3
`define REG_GRA 3'h4
`define REG_GRB 3'h5
`define REG_BRA 3'h6
`define REG_BRB 3'h7
`define NUM_CH 3

// unit-wide registers
`define OFF_MODE 8'h60
`define OFF_OUT_EN 8'h64
`define OFF_OUT_CTRL 8'h68

// control register fields
`define CTRL_START 0
`define CTRL_CLR 1
`define CTRL_CKS 3
`define CTRL_CAP_A 5
`define CTRL_CAP_B 6
`define CTRL_BUF_A 7
`define CTRL_BUF_B 8
`define CTRL_RESET 9'h000
`define CLR_ON_A 2'h1
`define CLR_ON_B 2'h2

// status and enable fields
`define FLAG_A 0
`define FLAG_B 1
`define FLAG_OVF 2

// mode register fields
`define MODE_PHASE 0
`define MODE_PWM 1
`define MODE_RESET 3'h0

// output control fields
`define OCTL_OLS_FIRST 0
`define OCTL_OLS_SECOND 1
`define OCTL_EXTERNAL_TRIGGER_DISABLE 4
`define OUT_CTRL_RESET 5'h13
`define OUT_EN_RESET 4'h0

// counter limits
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000

`endif

/* rtl/timer_pkg.sv */
package timer_pkg;

    typedef enum logic [1:0] {
        PWM_NORMAL = 2'b00,
        PWM_RESET_SYNC = 2'b01,
        PWM_COMPLEMENT = 2'b10
    } pwm_mode_e;

    typedef logic [15:0] count_t;

endpackage

/* rtl/timer_phase_count_buffer_flags.sv */
`timescale 1ns/100ps
`include "timer_defines.svh"
module timer_phase_count_buffer_flags #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // encoder inputs
    input wire logic phase_input_a,
    input wire logic phase_input_b,
    // capture inputs per channel and unit trigger
    input wire logic [2:0] capture_in_a,
    input wire logic [2:0] capture_in_b,
    input wire logic trigger_capture_a,
    // port fallback for pwm pins
    input wire logic [3:0] port_data_reg,
    input wire logic [3:0] port_dir_reg,
    // pwm pins, index 0 driven by channel one, 1 by channel two
    output logic [1:0] timer_pin_a_out,
    output logic [1:0] timer_pin_a_oe,
    output logic [1:0] timer_pin_b_out,
    output logic [1:0] timer_pin_b_oe,
    // interrupt requests per channel
    output logic [2:0] irq_cc_a,
    output logic [2:0] irq_cc_b,
    output logic [2:0] irq_ovf
);

////////////////////////////////////////////////////////////////////////////////
    localparam int NCH = `NUM_CH;

    function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
        input logic [CNT_W-1:0] wd, input logic [1:0] sel);
        logic [CNT_W-1:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}};
        merge16 = (old & ~m) | (wd & m);
    endfunction

    logic ack_reg;
    logic [31:0] rd_reg;
    logic [2:0] ps_reg;
    logic [2:0] mode_reg;
    logic [3:0] out_en_reg;
    logic [4:0] out_ctrl_reg;
    logic dn_reg;
    logic pa_s1, pa_s2, pa_prev, pb_s1, pb_s2, pb_prev;
    logic [31:0] rd_data;

    // per-channel views
    wire [CNT_W-1:0] cnt_w [NCH];
    wire [CNT_W-1:0] gra_w [NCH];
    wire [CNT_W-1:0] grb_w [NCH];
    wire [CNT_W-1:0] bra_w [NCH];
    wire [CNT_W-1:0] brb_w [NCH];
    wire [8:0] ctrl_w [NCH];
    wire [2:0] ier_w [NCH];
    wire [2:0] flag_w [NCH];
    wire [NCH-1:0] match_a_w, match_b_w, wrap_dn_w;

////////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire wb_wr = wb_req & wb_we_i & ~ack_reg;
    wire wb_rd = wb_req & ~wb_we_i & ~ack_reg;
    wire [1:0] sel_ch = wb_adr_i[6:5];
    wire [2:0] sel_reg = wb_adr_i[4:2];
    wire in_ch = ~wb_adr_i[7] & (sel_ch != 2'h3);
    wire wr_mode = wb_wr & (wb_adr_i == `OFF_MODE) & wb_sel_i[0];
    wire wr_out_en = wb_wr & (wb_adr_i == `OFF_OUT_EN) & wb_sel_i[0];
    wire wr_out_ctrl = wb_wr & (wb_adr_i == `OFF_OUT_CTRL) & wb_sel_i[0];

    // unit modes
    wire phase_mode = mode_reg[`MODE_PHASE];
    timer_pkg::pwm_mode_e pwm_mode;
    assign pwm_mode = timer_pkg::pwm_mode_e'(mode_reg[`MODE_PWM +: 2]);
    wire cmp_mode = (pwm_mode == timer_pkg::PWM_COMPLEMENT);
    wire pwm_any = (pwm_mode != timer_pkg::PWM_NORMAL);
    wire ols_first = out_ctrl_reg[`OCTL_OLS_FIRST];
    wire ols_second = out_ctrl_reg[`OCTL_OLS_SECOND];
    wire external_trigger_disable = out_ctrl_reg[`OCTL_EXTERNAL_TRIGGER_DISABLE];

    // timer clock enables from prescaler
    wire [3:0] tick = {ps_reg == 3'h7, ps_reg[1:0] == 2'h3, ps_reg[0], 1'b1};

    // phase edge detection on synchronised samples
    wire rise_a = pa_s2 & ~pa_prev;
    wire fall_a = ~pa_s2 & pa_prev;
    wire rise_b = pb_s2 & ~pb_prev;
    wire fall_b = ~pb_s2 & pb_prev;
    wire ph_up = (rise_b & ~pa_s2) | (rise_a & pb_s2) | (fall_b & pa_s2) | (fall_a & ~pb_s2);
    wire ph_dn = (fall_a & pb_s2) | (fall_b & ~pa_s2) | (rise_a & ~pb_s2) | (rise_b & pa_s2);

    // complementary reversal points
    wire turn_down = cmp_mode & match_a_w[1] & ~dn_reg;
    wire xfer_cmp = turn_down | (cmp_mode & wrap_dn_w[2]);
    wire trig_off = pwm_any & ~external_trigger_disable & trigger_capture_a;

////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pa_s1 <= 1'b0;
            pa_s2 <= 1'b0;
            pa_prev <= 1'b0;
            pb_s1 <= 1'b0;
            pb_s2 <= 1'b0;
            pb_prev <= 1'b0;
        end else begin
            pa_s1 <= phase_input_a;
            pa_s2 <= pa_s1;
            pa_prev <= pa_s2;
            pb_s1 <= phase_input_b;
            pb_s2 <= pb_s1;
            pb_prev <= pb_s2;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ps_reg <= 3'h0;
            dn_reg <= 1'b0;
        end else begin
            ps_reg <= ps_reg + 3'h1;
            if (!cmp_mode || (cmp_mode && wrap_dn_w[2])) begin
                dn_reg <= 1'b0;
            end else if (turn_down) begin
                dn_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `MODE_RESET;
            out_en_reg <= `OUT_EN_RESET;
            out_ctrl_reg <= `OUT_CTRL_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= wb_dat_i[2:0];
            end
            if (trig_off) begin
                out_en_reg <= 4'h0;
            end else if (wr_out_en) begin
                out_en_reg <= wb_dat_i[3:0];
            end
            if (wr_out_ctrl) begin
                out_ctrl_reg <= wb_dat_i[4:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // timer channels
    for (genvar c = 0; c < NCH; c++) begin : chan
        logic [8:0] ctrl_reg;
        logic [2:0] ier_reg, flag_reg, armed_reg;
        logic [CNT_W-1:0] cnt_reg, gra_reg, grb_reg, bra_reg, brb_reg;
        logic cap_a_prev, cap_b_prev;

        wire hit = wb_wr & in_ch & (sel_ch == 2'(c));
        wire rd_status = wb_rd & in_ch & (sel_ch == 2'(c)) & (sel_reg == `REG_STATUS);
        wire wr_ctrl = hit & (sel_reg == `REG_CTRL);
        wire wr_ier = hit & (sel_reg == `REG_IER) & wb_sel_i[0];
        wire wr_status = hit & (sel_reg == `REG_STATUS) & wb_sel_i[0];
        wire wr_cnt = hit & (sel_reg == `REG_CNT);
        wire wr_gra = hit & (sel_reg == `REG_GRA);
        wire wr_grb = hit & (sel_reg == `REG_GRB);
        wire buf_ok = (c != 0);
        wire wr_bra = hit & (sel_reg == `REG_BRA) & buf_ok;
        wire wr_brb = hit & (sel_reg == `REG_BRB) & buf_ok;
        wire [15:0] ctrl_m = merge16({7'h00, ctrl_reg}, wb_dat_i[15:0], wb_sel_i[1:0]);

        // phase mode replaces clock source and count direction on channel zero only
        wire phase_ch = (c == 0) & phase_mode;
        wire src = phase_ch ? (ph_up ^ ph_dn) : tick[ctrl_reg[`CTRL_CKS +: 2]];
        wire adv = ctrl_reg[`CTRL_START] & src;
        wire dn = phase_ch ? ph_dn : ((c != 0) & cmp_mode & dn_reg);
        wire cap_a_mode = ctrl_reg[`CTRL_CAP_A];
        wire cap_b_mode = ctrl_reg[`CTRL_CAP_B];
        wire cap_a = cap_a_mode & capture_in_a[c] & ~cap_a_prev;
        wire cap_b = cap_b_mode & capture_in_b[c] & ~cap_b_prev;
        wire match_a = adv & ~cap_a_mode & (cnt_reg == gra_reg);
        wire match_b = adv & ~cap_b_mode & (cnt_reg == grb_reg);
        wire wrap_up = adv & ~dn & (cnt_reg == `CNT_MAX);
        wire wrap_dn = adv & dn & (cnt_reg == `CNT_ZERO);
        wire [1:0] clr_sel = ctrl_reg[`CTRL_CLR +: 2];
        wire clr = ((clr_sel == `CLR_ON_A) & (match_a | cap_a)) | ((clr_sel == `CLR_ON_B) & (match_b | cap_b));
        wire buf_a = buf_ok & ctrl_reg[`CTRL_BUF_A];
        wire buf_b = buf_ok & ctrl_reg[`CTRL_BUF_B];
        wire xfer_ev_a = (pwm_mode == timer_pkg::PWM_NORMAL) ? match_a
            : (pwm_mode == timer_pkg::PWM_RESET_SYNC) ? match_a_w[1] : xfer_cmp;
        wire xfer_ev_b = (pwm_mode == timer_pkg::PWM_NORMAL) ? match_b
            : (pwm_mode == timer_pkg::PWM_RESET_SYNC) ? match_a_w[1] : xfer_cmp;
        wire xfer_a = buf_a & ~cap_a_mode & xfer_ev_a;
        wire xfer_b = buf_b & ~cap_b_mode & xfer_ev_b;
        wire flag_a_set = cap_a | (match_a & ~((c == 1) & cmp_mode & dn_reg));
        wire ovf_set = ((c == 2) & cmp_mode) ? wrap_dn : (wrap_up | wrap_dn);
        wire [2:0] set_v = {ovf_set, cap_b | match_b, flag_a_set};
        wire [2:0] clr_v = wr_status ? (armed_reg & ~wb_dat_i[2:0]) : 3'h0;

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                ctrl_reg <= `CTRL_RESET;
                ier_reg <= 3'h0;
                flag_reg <= 3'h0;
                armed_reg <= 3'h0;
                cap_a_prev <= 1'b0;
                cap_b_prev <= 1'b0;
            end else begin
                cap_a_prev <= capture_in_a[c];
                cap_b_prev <= capture_in_b[c];
                if (wr_ctrl) begin
                    ctrl_reg <= ctrl_m[8:0];
                end
                if (wr_ier) begin
                    ier_reg <= wb_dat_i[2:0];
                end
                flag_reg <= (flag_reg & ~clr_v) | set_v;
                if (rd_status) begin
                    armed_reg <= flag_reg;
                end else if (wr_status) begin
                    armed_reg <= 3'h0;
                end
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_reg <= `CNT_ZERO;
            end else if (wr_cnt) begin
                cnt_reg <= merge16(cnt_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
            end else if (clr) begin
                cnt_reg <= `CNT_ZERO;
            end else if (adv) begin
                cnt_reg <= dn ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                gra_reg <= `CNT_MAX;
                bra_reg <= `CNT_MAX;
            end else begin
                if (cap_a) begin
                    gra_reg <= cnt_reg;
                end else if (xfer_a) begin
                    gra_reg <= bra_reg;
                end else if (wr_gra) begin
                    gra_reg <= merge16(gra_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                if (cap_a && buf_a) begin
                    bra_reg <= gra_reg;
                end else if (wr_bra) begin
                    bra_reg <= merge16(bra_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                grb_reg <= `CNT_MAX;
                brb_reg <= `CNT_MAX;
            end else begin
                if (cap_b) begin
                    grb_reg <= cnt_reg;
                end else if (xfer_b) begin
                    grb_reg <= brb_reg;
                end else if (wr_grb) begin
                    grb_reg <= merge16(grb_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                if (cap_b && buf_b) begin
                    brb_reg <= grb_reg;
                end else if (wr_brb) begin
                    brb_reg <= merge16(brb_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
            end
        end

        assign cnt_w[c] = cnt_reg;
        assign gra_w[c] = gra_reg;
        assign grb_w[c] = grb_reg;
        assign bra_w[c] = buf_ok ? bra_reg : `CNT_ZERO;
        assign brb_w[c] = buf_ok ? brb_reg : `CNT_ZERO;
        assign ctrl_w[c] = ctrl_reg;
        assign ier_w[c] = ier_reg;
        assign flag_w[c] = flag_reg;
        assign match_a_w[c] = match_a;
        assign match_b_w[c] = match_b;
        assign wrap_dn_w[c] = wrap_dn;
        assign irq_cc_a[c] = flag_reg[`FLAG_A] & ier_reg[`FLAG_A];
        assign irq_cc_b[c] = flag_reg[`FLAG_B] & ier_reg[`FLAG_B];
        assign irq_ovf[c] = flag_reg[`FLAG_OVF] & ier_reg[`FLAG_OVF];

        if (c == 1) begin : chk
            a_capture_load: assert property (@(posedge mclk) disable iff (!rst_n)
                cap_a |=> (gra_reg == $past(cnt_reg)) && flag_reg[`FLAG_A])
                else $error("capture did not load counter and flag");
            a_buf_shift: assert property (@(posedge mclk) disable iff (!rst_n)
                (cap_a && buf_a) |=> (bra_reg == $past(gra_reg)))
                else $error("capture did not move old value to buffer");
            a_buf_compare: assert property (@(posedge mclk) disable iff (!rst_n)
                (xfer_a && !cap_a) |=> (gra_reg == $past(bra_reg)))
                else $error("buffer not transferred at match");
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // pwm pins with master enable, inversion and port fallback
    logic [1:0] lvl_a_reg, lvl_b_reg;
    wire [1:0] ols = {ols_second, ols_first};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_a_reg <= 2'h0;
            lvl_b_reg <= 2'h0;
        end else begin
            lvl_a_reg <= lvl_a_reg ^ match_a_w[2:1];
            lvl_b_reg <= lvl_b_reg ^ match_b_w[2:1];
        end
    end

    for (genvar p = 0; p < 2; p++) begin : pin
        wire me_a = out_en_reg[2*p];
        wire me_b = out_en_reg[2*p+1];
        assign timer_pin_a_out[p] = me_a ? (lvl_a_reg[p] ^ ~ols[p]) : port_data_reg[2*p];
        assign timer_pin_a_oe[p] = me_a | port_dir_reg[2*p];
        assign timer_pin_b_out[p] = me_b ? (lvl_b_reg[p] ^ ~ols[p]) : port_data_reg[2*p+1];
        assign timer_pin_b_oe[p] = me_b | port_dir_reg[2*p+1];
    end

////////////////////////////////////////////////////////////////////////////////
    // register read and bus answer
    always_comb begin
        rd_data = 32'h0000_0000;
        if (in_ch && sel_reg == `REG_CTRL) begin
            rd_data = {23'h000000, ctrl_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_IER) begin
            rd_data = {29'h00000000, ier_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_STATUS) begin
            rd_data = {29'h00000000, flag_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_CNT) begin
            rd_data = {16'h0000, cnt_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_GRA) begin
            rd_data = {16'h0000, gra_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_GRB) begin
            rd_data = {16'h0000, grb_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_BRA) begin
            rd_data = {16'h0000, bra_w[sel_ch]};
        end else if (in_ch && sel_reg == `REG_BRB) begin
            rd_data = {16'h0000, brb_w[sel_ch]};
        end else if (wb_adr_i == `OFF_MODE) begin
            rd_data = {29'h00000000, mode_reg};
        end else if (wb_adr_i == `OFF_OUT_EN) begin
            rd_data = {28'h0000000, out_en_reg};
        end else if (wb_adr_i == `OFF_OUT_CTRL) begin
            rd_data = {27'h0000000, out_ctrl_reg};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
            if (wb_rd) begin
                rd_reg <= rd_data;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rd_reg;

////////////////////////////////////////////////////////////////////////////////
    wire ch0_quiet = ~(wb_wr & in_ch & (sel_ch == 2'h0)) & ~chan[0].clr;

    a_phase_up: assert property (@(posedge mclk) disable iff (!rst_n)
        (phase_mode && ctrl_w[0][`CTRL_START] && ph_up && !ph_dn && ch0_quiet)
        |=> (cnt_w[0] == $past(cnt_w[0]) + 16'h0001))
        else $error("phase up edge did not increment");
    a_phase_down: assert property (@(posedge mclk) disable iff (!rst_n)
        (phase_mode && ctrl_w[0][`CTRL_START] && ph_dn && !ph_up && ch0_quiet)
        |=> (cnt_w[0] == $past(cnt_w[0]) - 16'h0001))
        else $error("phase down edge did not decrement");
    a_ovf_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        (chan[0].wrap_up || chan[0].wrap_dn) |=> flag_w[0][`FLAG_OVF])
        else $error("wrap did not set overflow");
    a_match_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (cnt_w[0] == gra_w[0] && !ctrl_w[0][`CTRL_CAP_A] && !chan[0].adv)
        |=> !$rose(flag_w[0][`FLAG_A]) || $past(chan[0].cap_a))
        else $error("compare flag set before counter advanced");
    a_trig_disable: assert property (@(posedge mclk) disable iff (!rst_n)
        trig_off |=> (out_en_reg == 4'h0) && (timer_pin_a_oe == {port_dir_reg[2], port_dir_reg[0]}))
        else $error("trigger did not clear master enables");
    a_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag_w[0][`FLAG_A] && !chan[0].armed_reg[`FLAG_A]) |=> flag_w[0][`FLAG_A])
        else $error("flag cleared without prior read");
    a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(irq_ovf[0]) |-> ier_w[0][`FLAG_OVF] && ($rose(flag_w[0][`FLAG_OVF]) || $rose(ier_w[0][`FLAG_OVF])))
        else $error("overflow request without flag and enable");

endmodule

/* verif/encoder_model.sv */
`timescale 1ns/100ps
module encoder_model (
    // clock
    input wire logic mclk,
    // phase pins
    output logic phase_input_a,
    output logic phase_input_b
);
    int pos = 0;
    initial begin
        phase_input_a = 1'b0;
        phase_input_b = 1'b0;
    end
    // one gray step per edge, each level held four clocks
    task automatic move(input int n, input bit up);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            pos = up ? (pos + 1) % 4 : (pos + 3) % 4;
            phase_input_a <= pos[1];
            phase_input_b <= pos[1] ^ pos[0];
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/100ps
module tb;
    logic mclk = 0, rst_n = 0, we = 0, cyc = 0, stb = 0, trg = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, q;
    logic [2:0] cap_a = 3'h0, cap_b = 3'h0, ia, ib, io;
    logic [3:0] pd = 4'h5, pdir = 4'h3;
    logic [1:0] pao, paoe, pbo, pboe;
    logic ack, pa, pb;
    int err_total = 0, n_checks = 0, cyc_n = 0;
    ////////////////////////////////////////////////////////////
    timer_phase_count_buffer_flags timer_phase_count_buffer_flags_i (
        .mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'h3),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack),
        .phase_input_a(pa), .phase_input_b(pb), .capture_in_a(cap_a), .capture_in_b(cap_b),
        .trigger_capture_a(trg), .port_data_reg(pd), .port_dir_reg(pdir),
        .timer_pin_a_out(pao), .timer_pin_a_oe(paoe), .timer_pin_b_out(pbo),
        .timer_pin_b_oe(pboe), .irq_cc_a(ia), .irq_cc_b(ib), .irq_ovf(io));
    encoder_model encoder_model_i (.mclk(mclk), .phase_input_a(pa), .phase_input_b(pb));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            err_total++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // classic cycle, held until ack seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {16'h0000, d};
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 16'h0);
        chk(q, exp);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(8'h68, 32'h13);
        rchk(8'h6C, 32'h0);
        rchk(8'h50, 32'hFFFF);
        wb(1'b1, 8'h18, 16'h5555);
        rchk(8'h18, 32'h0);
    endtask
    task automatic t_phase();
        wb(1'b1, 8'h60, 16'h1);
        wb(1'b1, 8'h00, 16'h19);
        wb(1'b1, 8'h04, 16'h4);
        encoder_model_i.move(6, 1'b1);
        repeat (6) @(posedge mclk);
        rchk(8'h0C, 32'h6);
        encoder_model_i.move(8, 1'b0);
        repeat (6) @(posedge mclk);
        rchk(8'h0C, 32'hFFFE);
        rchk(8'h08, 32'h7);
        chk({io, ia}, {3'h1, 3'h0});
        wb(1'b1, 8'h08, 16'h0);
        rchk(8'h08, 32'h0);
        chk(io, 3'h0);
    endtask
    task automatic t_buffer();
        wb(1'b1, 8'h30, 16'h00AA);
        wb(1'b1, 8'h2C, 16'h1234);
        wb(1'b1, 8'h20, 16'hA0);
        @(posedge mclk) cap_a <= 3'h2;
        repeat (2) @(posedge mclk);
        cap_a <= 3'h0;
        rchk(8'h30, 32'h1234);
        rchk(8'h38, 32'h00AA);
        rchk(8'h28, 32'h1);
        wb(1'b1, 8'h50, 16'h3);
        wb(1'b1, 8'h58, 16'h7);
        wb(1'b1, 8'h40, 16'h81);
        repeat (10) @(posedge mclk);
        rchk(8'h50, 32'h7);
        rchk(8'h48, 32'h1);
    endtask
    task automatic t_trigger();
        wb(1'b1, 8'h60, 16'h2);
        wb(1'b1, 8'h68, 16'h3);
        wb(1'b1, 8'h64, 16'hF);
        chk(paoe, 2'h3);
        @(posedge mclk) trg <= 1'b1;
        @(posedge mclk) trg <= 1'b0;
        rchk(8'h64, 32'h0);
        chk({pao, paoe}, 4'hD);
    endtask
    task automatic t_pwm();
        logic [3:0] v;
        wb(1'b1, 8'h40, 16'h0000);
        wb(1'b1, 8'h4C, 16'h0000);
        wb(1'b1, 8'h54, 16'h0100);
        wb(1'b1, 8'h5C, 16'h0022);
        wb(1'b1, 8'h40, 16'h0100);
        wb(1'b1, 8'h30, 16'h0004);
        wb(1'b1, 8'h2C, 16'h0000);
        wb(1'b1, 8'h24, 16'h0001);
        wb(1'b1, 8'h04, 16'h0002);
        wb(1'b1, 8'h20, 16'h0003);
        repeat (8) @(posedge mclk);
        rchk(8'h54, 32'h22);
        chk({ib, ia}, 6'h0A);
        wb(1'b1, 8'h64, 16'h000C);
        v = {pao[1], pbo[1], paoe[1], pboe[1]};
        chk(v[1:0], 2'h3);
        wb(1'b1, 8'h68, 16'h0001);
        chk({pao[1], pbo[1]}, v[3:2] ^ 2'h3);
        wb(1'b1, 8'h20, 16'h0000);
        wb(1'b1, 8'h60, 16'h0000);
        wb(1'b1, 8'h30, 16'h000C);
        wb(1'b1, 8'h2C, 16'h0008);
        wb(1'b1, 8'h34, 16'h0040);
        wb(1'b1, 8'h3C, 16'h0033);
        wb(1'b1, 8'h60, 16'h0004);
        wb(1'b1, 8'h40, 16'h0001);
        wb(1'b1, 8'h20, 16'h0101);
        repeat (12) @(posedge mclk);
        rchk(8'h34, 32'h33);
        wb(1'b1, 8'h3C, 16'h0055);
        repeat (24) @(posedge mclk);
        rchk(8'h34, 32'h55);
        rchk(8'h48, 32'h5);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_phase();
        t_buffer();
        t_trigger();
        t_pwm();
        finish_test();
    end
endmodule
